// File: rtl/line_sense_pkg.sv
// Package of register map, field layout and timing constants for line sensing control
`default_nettype none
package line_sense_pkg;
	// Register word indexes (byte address is four times the index)
	localparam logic [7:0] IDX_RING_THRESHOLD  = 8'h0e;
	localparam logic [7:0] IDX_RX_BOOST        = 8'h14;
	localparam logic [7:0] IDX_CALLER_ID_ROUTE = 8'h15;
	localparam logic [7:0] IDX_DETECT_ENABLE   = 8'h20;
	localparam logic [7:0] IDX_LINE_STATUS     = 8'h21;
	localparam logic [7:0] IDX_IRQ_STATUS      = 8'h22;
	localparam logic [7:0] IDX_IRQ_MASK        = 8'h23;
	localparam logic [7:0] IDX_RING_FLAG       = 8'h24;
	localparam int         ADDR_W              = 10;

	// Field positions
	localparam int RX_BOOST_BIT   = 3;
	localparam int CID_ROUTE_BIT  = 4;
	localparam int RING_TH_LSB    = 0;
	localparam int RING_TH_W      = 2;
	// Detect enable register bits
	localparam int EN_MASTER      = 0;
	localparam int EN_UNDER_V     = 1;
	localparam int EN_OVER_V      = 2;
	localparam int EN_OVER_I      = 3;
	localparam int EN_PARALLEL    = 4;
	localparam int EN_REVERSAL    = 5;
	localparam int EN_AC_OVERLOAD = 6;
	localparam int OV_HIGH_SEL    = 7;
	localparam int LINE_PWR_SEL   = 8;
	localparam int EN_W           = 9;
	// Event bits shared by status and mask
	localparam int EV_UNDER_V     = 0;
	localparam int EV_OVER_V      = 1;
	localparam int EV_OVER_I      = 2;
	localparam int EV_PARALLEL    = 3;
	localparam int EV_REVERSAL    = 4;
	localparam int EV_AC_OVERLOAD = 5;
	localparam int EV_RING        = 6;
	localparam int EV_W           = 7;

	// Reset values
	localparam logic [7:0]      RST_CTRL_BYTE = 8'h00;
	localparam logic [EN_W-1:0] RST_ENABLE    = 9'h000;
	localparam logic [EV_W-1:0] RST_MASK      = 7'h00;

	// Register bus answer latency
	localparam int READ_WAIT_CYCLES = 1;
endpackage
`default_nettype wire

// File: rtl/event_latch.sv
// Sticky event flag: set on event, cleared by request, set wins
`default_nettype none
module event_latch
	import line_sense_pkg::*;
#(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Events and clears
	input  wire logic [WIDTH-1:0] setPulse,
	input  wire logic [WIDTH-1:0] clearReq,
	// Flags
	output logic      [WIDTH-1:0] flag
);
	// Set has priority over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			flag <= '0;
		else
			flag <= setPulse | (flag & ~clearReq);
	end
endmodule
`default_nettype wire

// File: rtl/edge_rise.sv
// Rising edge detector for synchronous level inputs
`default_nettype none
module edge_rise #(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Levels in, pulses out
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] prevLevel;

	// Previous sample
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			prevLevel <= '0;
		else
			prevLevel <= level;
	end

	assign rise = level & ~prevLevel;
endmodule
`default_nettype wire

// File: rtl/line_sense_protect_ctrl.sv
// Line sensing and protection control with Avalon-MM register slave
// Function
// - While off-hook, flag a parallel handset going off-hook and tell host.
// - Detect polarity reversal only while on-hook, announcing caller identity data.
// - Off-hook caller identity tones use the ordinary receive path.
// - Enabled over-voltage or over-current forces on-hook without host action.
// - Line-powered mode falls back to barrier power on under-voltage, autonomously.
// - Each detector has status; all but ring have an enable, and master enable gates all but ring.
// - Enabled under-voltage asserts a condition usable as host interrupt.
// - Over-voltage trip selectable between lower and higher threshold.
// - AC overload indication, shared with billing tone detect, above peak level.
// - Write-only receive boost bit adds fixed gain; default zero.
// - Caller ID mode routes ring sense into receive filter, normal path off.
// - Zero ring threshold disables ring detection; host programs non-zero.
// - Ring or reversal above threshold latches flag, cleared by host read.
//
// Design decision made here: the Avalon-MM slave port.
`default_nettype none
module line_sense_protect_ctrl
	import line_sense_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	output logic                   response_err,
	// Hook state request from host logic
	input  wire logic              offHookReq,
	// Line sense comparator inputs
	input  wire logic              underVoltageSense,
	input  wire logic              overVoltageLowSense,
	input  wire logic              overVoltageHighSense,
	input  wire logic              overCurrentSense,
	input  wire logic              acPeakOverSense,
	input  wire logic              parallelDropSense,
	input  wire logic              polarityFlipSense,
	input  wire logic [1:0]        ringSenseLevel,
	// Analog path controls
	output logic                   offHook,
	output logic                   barrierPowered,
	output logic                   rxGainBoost,
	output logic                   callerIdRouteEn,
	output logic                   normalRxPathEn,
	output logic [1:0]             ringDetectThreshold,
	output logic                   acOverloadIndication,
	// Interrupt
	output logic                   irq
);
	// Control fields, sticky flags and read wait state
	logic [7:0]      ringThresholdReg;
	logic [7:0]      rxBoostReg;
	logic [7:0]      callerIdReg;
	logic [EN_W-1:0] detectEnable;
	logic [EV_W-1:0] irqMask;
	logic [EV_W-1:0] irqStatus;
	logic            ringEventFlag;
	logic            tripLatched;
	logic            readPending;

	// Bus decode
	logic [7:0] wordIndex;
	logic       isMapped;
	logic       doWrite;
	logic       readAccept;

	// Detector status levels
	logic            masterOn;
	logic [EV_W-1:0] detectLevel;
	logic [EV_W-1:0] detectRise;
	logic [EV_W-1:0] irqClear;
	logic            ringClear;
	logic            overVoltageHit;
	logic            ringAboveThreshold;
	logic            enterLinePower;

	// Decode of a word index against the map
	function automatic logic mapped(input logic [7:0] idx);
		return idx == IDX_RING_THRESHOLD || idx == IDX_RX_BOOST ||
			idx == IDX_CALLER_ID_ROUTE || idx == IDX_DETECT_ENABLE ||
			idx == IDX_LINE_STATUS || idx == IDX_IRQ_STATUS ||
			idx == IDX_IRQ_MASK || idx == IDX_RING_FLAG;
	endfunction

	// Qualified access hitting one word index
	function automatic logic hitWord(input logic en, input logic [7:0] idx, input logic [7:0] target);
		return en && idx == target;
	endfunction

	assign wordIndex  = address[ADDR_W-1:2];
	assign isMapped   = mapped(wordIndex);
	assign doWrite    = write && byteenable[0];
	assign readAccept = read && readPending;

	// Writes complete at once; reads answer one cycle later
	assign waitrequest = read && !readPending;

	// Read wait state
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			readPending <= 1'b0;
		else
			readPending <= read && !readPending;
	end

	// Control field registers, held until rewritten
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ringThresholdReg <= RST_CTRL_BYTE;
			rxBoostReg       <= RST_CTRL_BYTE;
			callerIdReg      <= RST_CTRL_BYTE;
			detectEnable     <= RST_ENABLE;
			irqMask          <= RST_MASK;
		end
		else if (doWrite)
		begin
			unique case (wordIndex)
				// Ring threshold field
				IDX_RING_THRESHOLD:  ringThresholdReg <= writedata[7:0];
				// Receive boost
				IDX_RX_BOOST:        rxBoostReg <= writedata[7:0];
				// Caller ID routing
				IDX_CALLER_ID_ROUTE: callerIdReg <= writedata[7:0];
				// Detector enables and power select
				IDX_DETECT_ENABLE:   detectEnable <= writedata[EN_W-1:0];
				// Interrupt mask
				IDX_IRQ_MASK:        irqMask <= writedata[EV_W-1:0];
				// Read-only or unmapped words
				default:             ;
			endcase
		end
	end

	// Path controls from write-only fields
	assign rxGainBoost         = rxBoostReg[RX_BOOST_BIT];
	assign callerIdRouteEn     = callerIdReg[CID_ROUTE_BIT];
	assign normalRxPathEn      = !callerIdReg[CID_ROUTE_BIT];
	assign ringDetectThreshold = ringThresholdReg[RING_TH_LSB +: RING_TH_W];

	// Detector qualification by individual and master enables
	assign masterOn       = detectEnable[EN_MASTER];
	assign overVoltageHit = detectEnable[OV_HIGH_SEL] ? overVoltageHighSense
		: overVoltageLowSense;
	// Ring sense level compared with programmed threshold; zero disables
	assign ringAboveThreshold = (ringDetectThreshold != 2'h0)
		&& (ringSenseLevel >= ringDetectThreshold);

	// Qualified detector levels
	always_comb
	begin
		detectLevel = '0;
		// Under-voltage, usable as an interrupt
		detectLevel[EV_UNDER_V] = masterOn && detectEnable[EN_UNDER_V]
			&& underVoltageSense;
		// Over-voltage at the selected trip level
		detectLevel[EV_OVER_V] = masterOn && detectEnable[EN_OVER_V] && overVoltageHit;
		// Over-current
		detectLevel[EV_OVER_I] = masterOn && detectEnable[EN_OVER_I] && overCurrentSense;
		// Parallel pick-up, only while off-hook
		detectLevel[EV_PARALLEL] = masterOn && detectEnable[EN_PARALLEL]
			&& offHook && parallelDropSense;
		// Polarity reversal, only while on-hook
		detectLevel[EV_REVERSAL] = masterOn && detectEnable[EN_REVERSAL]
			&& !offHook && polarityFlipSense;
		// AC overload, shared with the billing tone path
		detectLevel[EV_AC_OVERLOAD] = masterOn && detectEnable[EN_AC_OVERLOAD]
			&& acPeakOverSense;
		// Ring above threshold, gated by threshold and on-hook only
		detectLevel[EV_RING] = !offHook && ringAboveThreshold;
	end

	// Event edges
	edge_rise #(
		.WIDTH (EV_W)
	) u_edges (
		.clock (clock),
		.rst_n (rst_n),
		.level (detectLevel),
		.rise  (detectRise)
	);

	// Write one to clear interrupt status
	assign irqClear = hitWord(doWrite, wordIndex, IDX_IRQ_STATUS) ? writedata[EV_W-1:0] : '0;

	// Writing the line-powered select enters line power
	assign enterLinePower = hitWord(doWrite, wordIndex, IDX_DETECT_ENABLE)
		&& writedata[LINE_PWR_SEL];

	event_latch #(
		.WIDTH (EV_W)
	) u_irq_status (
		.clock    (clock),
		.rst_n    (rst_n),
		.setPulse (detectRise),
		.clearReq (irqClear),
		.flag     (irqStatus)
	);

	// Ring or reversal flag, cleared by read
	assign ringClear = hitWord(readAccept, wordIndex, IDX_RING_FLAG);

	event_latch #(
		.WIDTH (1)
	) u_ring_flag (
		.clock    (clock),
		.rst_n    (rst_n),
		.setPulse (detectRise[EV_RING] | detectRise[EV_REVERSAL]),
		.clearReq (ringClear),
		.flag     (ringEventFlag)
	);

	// Protection trip forces on-hook until host drops its request
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			tripLatched <= 1'b0;
		else if (detectLevel[EV_OVER_V] || detectLevel[EV_OVER_I])
			tripLatched <= 1'b1;
		else if (!offHookReq)
			tripLatched <= 1'b0;
	end

	// Hook output
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			offHook <= 1'b0;
		else
			offHook <= offHookReq && !tripLatched
				&& !detectLevel[EV_OVER_V] && !detectLevel[EV_OVER_I];
	end

	// Power mode: line power on select write, barrier power held after under-voltage
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			barrierPowered <= 1'b1;
		else if (enterLinePower)
			barrierPowered <= 1'b0;
		else if (!detectEnable[LINE_PWR_SEL])
			barrierPowered <= 1'b1;
		else if (detectLevel[EV_UNDER_V])
			barrierPowered <= 1'b1;
	end

	// Overload indication registered
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			acOverloadIndication <= 1'b0;
		else
			acOverloadIndication <= detectLevel[EV_AC_OVERLOAD];
	end

	// Read data path
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			readdata     <= 32'h0000_0000;
			response_err <= 1'b0;
		end
		else
		begin
			readdata     <= 32'h0000_0000;
			response_err <= (read || write) && !isMapped;
			if (read && !readPending)
			begin
				unique case (wordIndex)
					// Live detector levels
					IDX_LINE_STATUS:
						readdata[EV_W-1:0] <= detectLevel;
					// Sticky interrupt status
					IDX_IRQ_STATUS:
						readdata[EV_W-1:0] <= irqStatus;
					// Interrupt mask
					IDX_IRQ_MASK:
						readdata[EV_W-1:0] <= irqMask;
					// Ring or reversal flag, cleared by this read
					IDX_RING_FLAG:
						readdata[0] <= ringEventFlag;
					// Detector enables
					IDX_DETECT_ENABLE:
						readdata[EN_W-1:0] <= detectEnable;
					// Write-only and unmapped words read zero
					default:
						readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Interrupt level
	assign irq = |(irqStatus & irqMask);
endmodule
`default_nettype wire

// File: tb/line_sense_chk.sv
// Port checker of the line sensing controller, bound into the design
`default_nettype none
module line_sense_chk
	import line_sense_pkg::*;
(
	// Clock, reset and bus
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       writedata,
	input wire logic [3:0]        byteenable,
	input wire logic              waitrequest,
	// Line side
	input wire logic              offHookReq,
	input wire logic              acPeakOverSense,
	input wire logic              offHook,
	input wire logic              rxGainBoost,
	input wire logic              callerIdRouteEn,
	input wire logic              normalRxPathEn,
	input wire logic [1:0]        ringDetectThreshold,
	input wire logic              acOverloadIndication
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Accepted control writes show at the analog controls
	boost_write_a: assert property (
		write && byteenable[0] && address[ADDR_W-1:2] == IDX_RX_BOOST
		|=> rxGainBoost == $past(writedata[RX_BOOST_BIT]))
		else $error("boost write lost");
	cid_write_a: assert property (
		write && byteenable[0] && address[ADDR_W-1:2] == IDX_CALLER_ID_ROUTE
		|=> callerIdRouteEn == $past(writedata[CID_ROUTE_BIT]))
		else $error("route write lost");
	thresh_write_a: assert property (
		write && byteenable[0] && address[ADDR_W-1:2] == IDX_RING_THRESHOLD
		|=> ringDetectThreshold == $past(writedata[RING_TH_LSB +: RING_TH_W]))
		else $error("threshold write lost");
	// Path selection, defaults and causes
	path_swap_a: assert property (
		write && byteenable[0] && address[ADDR_W-1:2] == IDX_CALLER_ID_ROUTE
		|=> normalRxPathEn == !$past(writedata[CID_ROUTE_BIT]))
		else $error("normal path not swapped");
	reset_default_a: assert property ($rose(rst_n) |-> !rxGainBoost && !callerIdRouteEn
		&& ringDetectThreshold == 2'h0) else $error("controls not at default");
	hook_cause_a: assert property (offHook |-> $past(offHookReq))
		else $error("off-hook without request");
	ac_cause_a: assert property (acOverloadIndication |-> $past(acPeakOverSense))
		else $error("overload without peak");
	// Bus answer timing
	read_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
		else $error("read answer timing");
endmodule
bind line_sense_protect_ctrl line_sense_chk u_line_sense_chk (.*);
`default_nettype wire

// File: tb/pstn_line_model.sv
// Behavioural telephone line driving the sense comparator pins
`default_nettype none
module pstn_line_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Line conditions asked for by the bench
	input  wire logic [6:0] lineCond,
	input  wire logic [1:0] ringMag,
	// Comparator levels toward the controller
	output logic      [6:0] sense,
	output logic      [1:0] ringLevel
);
	// Comparators settle one cycle after the line changes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sense <= 7'h00;
			ringLevel <= 2'h0;
		end
		else
		begin
			sense <= lineCond;
			ringLevel <= ringMag;
		end
	end
endmodule
`default_nettype wire

// File: tb/test_line_sense_protect_ctrl.sv
// Self-checking bench of the line sensing and protection controller
`default_nettype none
module test_line_sense_protect_ctrl
	import line_sense_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observed signals
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] address = 10'h000;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = 32'h0;
	logic [3:0]        byteenable = 4'h0;
	logic [3:0]        beSel = 4'h1;
	logic              offHookReq = 1'b0;
	logic [6:0]        lineCond = 7'h00;
	logic [1:0]        ringMag = 2'h0;
	logic [6:0]        sense;
	logic [1:0]        ringLevel;
	logic [31:0]       readdata, rv;
	logic              waitrequest, offHook, barrierPowered, rxGainBoost, callerIdRouteEn;
	logic              normalRxPathEn, acOverloadIndication, irq;
	logic [1:0]        ringDetectThreshold;
	int                bad_count = 0;
	int                checked = 0;
	// Design and line model
	line_sense_protect_ctrl u_line_sense_protect_ctrl (.clock(clock), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.response_err(), .offHookReq(offHookReq), .underVoltageSense(sense[0]),
		.overVoltageLowSense(sense[1]), .overVoltageHighSense(sense[2]),
		.overCurrentSense(sense[3]), .acPeakOverSense(sense[4]), .parallelDropSense(sense[5]),
		.polarityFlipSense(sense[6]), .ringSenseLevel(ringLevel), .offHook(offHook),
		.barrierPowered(barrierPowered), .rxGainBoost(rxGainBoost),
		.callerIdRouteEn(callerIdRouteEn), .normalRxPathEn(normalRxPathEn),
		.ringDetectThreshold(ringDetectThreshold), .acOverloadIndication(acOverloadIndication),
		.irq(irq));
	pstn_line_model u_pstn_line_model (.clock(clock), .rst_n(rst_n), .lineCond(lineCond),
		.ringMag(ringMag), .sense(sense), .ringLevel(ringLevel));
	// Clock and watchdog
	always #10 clock = ~clock;
	initial
	begin
		#100000;
		check(32'h1, 32'h0);
		summarize();
	end
	// Shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge clock);
	endtask
	// One bus cycle, held until waitrequest is seen low
	task automatic access(input logic isWrite, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		address <= {idx, 2'h0};
		write <= isWrite;
		read <= !isWrite;
		writedata <= wd;
		byteenable <= beSel;
		@(negedge clock);
		while (waitrequest !== 1'b0 && n < 50)
		begin
			n++;
			@(negedge clock);
		end
		check(32'(n >= 50), 32'h0);
		rv = readdata;
		@(posedge clock);
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		access(1'b1, i, d);
	endtask
	task automatic rd(input logic [7:0] i);
		access(1'b0, i, 32'h0);
	endtask
	task automatic line(input logic [6:0] c, input int k);
		lineCond <= c;
		idle(k);
	endtask
	task automatic calm();
		lineCond <= 7'h00;
		offHookReq <= 1'b0;
		idle(2);
		wr(IDX_IRQ_STATUS, 32'h7f);
	endtask
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		idle(1);
		check(32'({rxGainBoost, callerIdRouteEn, normalRxPathEn, ringDetectThreshold}),
			32'h4);
		wr(IDX_RX_BOOST, 32'h8);
		wr(IDX_CALLER_ID_ROUTE, 32'h10);
		beSel <= 4'h0;
		wr(IDX_RX_BOOST, 32'h0);
		beSel <= 4'h1;
		idle(1);
		check(32'({rxGainBoost, callerIdRouteEn, normalRxPathEn}), 32'h6);
		for (int t = 0; t < 4; t++)
		begin
			wr(IDX_RING_THRESHOLD, 32'(t));
			idle(1);
			check(32'(ringDetectThreshold), 32'(t));
		end
		wr(IDX_IRQ_MASK, 32'h7f);
		wr(IDX_DETECT_ENABLE, 32'h31);
		offHookReq <= 1'b1;
		line(7'h60, 5);
		check(32'(irq), 32'h1);
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h8);
		wr(IDX_IRQ_MASK, 32'h0);
		idle(1);
		check(32'(irq), 32'h0);
		calm();
		line(7'h60, 4);
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h10);
		rd(IDX_RING_FLAG);
		check(rv, 32'h1);
		calm();
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h0);
		wr(IDX_DETECT_ENABLE, 32'h8);
		offHookReq <= 1'b1;
		line(7'h08, 5);
		check(32'(offHook), 32'h1);
		wr(IDX_DETECT_ENABLE, 32'h9);
		idle(4);
		check(32'(offHook), 32'h0);
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h4);
		calm();
		for (int s = 0; s < 2; s++)
		begin
			wr(IDX_DETECT_ENABLE, s ? 32'h85 : 32'h05);
			offHookReq <= 1'b1;
			line(7'h02, 5);
			check(32'(offHook), 32'(s));
			calm();
		end
		wr(IDX_DETECT_ENABLE, 32'h103);
		idle(1);
		check(32'(barrierPowered), 32'h0);
		line(7'h01, 4);
		check(32'(barrierPowered), 32'h1);
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h1);
		calm();
		check(32'(barrierPowered), 32'h1);
		wr(IDX_DETECT_ENABLE, 32'h41);
		line(7'h10, 3);
		check(32'(acOverloadIndication), 32'h1);
		rd(IDX_IRQ_STATUS);
		check(rv, 32'h20);
		calm();
		wr(IDX_RING_THRESHOLD, 32'h0);
		ringMag <= 2'h3;
		idle(4);
		rd(IDX_RING_FLAG);
		check(rv, 32'h0);
		wr(IDX_RING_THRESHOLD, 32'h1);
		ringMag <= 2'h2;
		idle(4);
		ringMag <= 2'h0;
		rd(IDX_RING_FLAG);
		check(rv, 32'h1);
		rd(IDX_RING_FLAG);
		check(rv, 32'h0);
		rd(8'h3f);
		check(rv, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
